// File: hdl/ecl_pkg.sv
/*
 * constants, types and register map of the preload word loader.
 * assumes one 100 MHz clock and a word reader on the same clock.
 */
// What this block does
// - word 66h bit 0 -> port3 slot implemented
// - word 66h bit 1 -> port3 connector clock
// - word 66h bit 2 -> port3 init required
// - word 66h bit 3 -> port3 low priority vc
// - word 66h bits 6:4 -> port3 port number
// - word 66h bits 15:9 -> port3 tc map
// - words 70h-76h are port 0-3 budgets
// - budget bits 9:0 -> base power, scale
// - budget bits 11:10 -> pm state field
// - budget bit 15 -> system allocated flag
// - words 80h,82h pm control ports 0,1
// - pm bits: d3 l1, l1 delay, l0s
// - pm bit 6 -> rx polarity disable
// - pm bit 7 -> vga decode enable
// - pm bits 15:8 -> phy control byte
// - words 60h-64h same layout, ports 0-2
// - words 84h,86h same layout, ports 2,3
package ecl_pkg;

    localparam int PORT_CNT = 4;
    localparam int WORD_CNT = 12;
    localparam int WORD_W = 16;
    localparam int IDX_W = 4;

    // preload word addresses (byte address in the memory)
    localparam logic [7:0] SLOT_WORD_BASE = 8'h60;
    localparam logic [7:0] PB_WORD_BASE = 8'h70;
    localparam logic [7:0] PM_WORD_BASE = 8'h80;

    // word groups, index bits [3:2]
    localparam logic [1:0] GRP_SLOT = 2'h0;
    localparam logic [1:0] GRP_PB = 2'h1;
    localparam logic [1:0] GRP_PM = 2'h2;

    // source bit positions inside the slot word
    localparam int SLOT_BIT = 0;
    localparam int CLK_BIT = 1;
    localparam int DSI_BIT = 2;
    localparam int LOW_PRIO_BIT = 3;
    localparam int PNUM_LSB = 4;
    localparam int TCMAP_LSB = 9;
    // power budget word
    localparam int BPWR_LSB = 0;
    localparam int SCALE_LSB = 8;
    localparam int PMST_LSB = 10;
    localparam int SYSAL_BIT = 15;
    // power management control word
    localparam int PMCTL_LSB = 0;
    localparam int RXPOL_BIT = 6;
    localparam int VGA_BIT = 7;
    localparam int PHY_LSB = 8;

    // apb map
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_RAW = 12'h040;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int CTRL_IGNORE_BIT = 1;
    localparam logic CTRL_IGNORE_RST = 1'b0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_NOMEM_BIT = 2;
    localparam int STAT_IDX_LSB = 4;

    // wait after reset so the presence synchroniser has settled
    localparam logic [1:0] SETTLE_CYC = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_REQ,
        ST_WAIT,
        ST_DONE
    } ecl_state_e;

    // per-port fields; comments give the config offset and bits
    typedef struct packed {
        logic slot_impl;               // c0h [24]
        logic slot_clk_cfg;            // d0h [28]
        logic dsi_req;                 // 40h [21]
        logic low_priority_vc_group;   // 144h [4]
        logic [2:0] port_num;          // cch [26:24]
        logic [6:0] tc_vc0_map;        // 154h [7:1]
        logic [7:0] base_power;        // 214h [7:0]
        logic [1:0] data_scale;        // 214h [9:8]
        logic [1:0] pm_state;          // 214h [14:13]
        logic sys_alloc;               // 218h [0]
        logic [5:0] pm_ctrl;           // 74h [13:8]
        logic rx_pol_dis;              // 74h [14]
        logic vga_en;                  // 70h [31]
        logic [7:0] phy_ctrl_status_five; // 88h [31:24]
    } ecl_port_cfg_s;

    localparam ecl_port_cfg_s CFG_RST = '0;

    typedef struct packed {
        logic req;
        logic [7:0] addr;
    } ecl_mem_req_s;

    typedef struct packed {
        logic ack;
        logic [15:0] data;
    } ecl_mem_rsp_s;

endpackage

// File: hdl/ecl_sync.sv
/*
 * two flip-flop synchroniser for one level.
 * assumes the input may change at any time relative to ref_clk.
 */
`timescale 1ns/100ps
module ecl_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// File: hdl/ecl_word_ram.sv
/*
 * small memory holding the raw preload words as loaded.
 * read data come out of a register, one cycle after the address.
 */
`timescale 1ns/100ps
module ecl_word_ram (
    input wire logic ref_clk,
    input wire logic we,
    input wire logic [ecl_pkg::IDX_W-1:0] waddr,
    input wire logic [ecl_pkg::WORD_W-1:0] wdata,
    input wire logic [ecl_pkg::IDX_W-1:0] raddr,
    output logic [ecl_pkg::WORD_W-1:0] rdata_q
);
    logic [ecl_pkg::WORD_W-1:0] mem_q [2**ecl_pkg::IDX_W];

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        rdata_q <= mem_q[raddr];
    end
endmodule

// File: hdl/ecl_loader.sv
/*
 * preload word loader: after reset it reads the port slot, power
 * budget and power management words from the configuration memory
 * and spreads them over the per-port configuration fields.
 * every load starts from the field defaults, so a reload with the
 * memory gone leaves every field at its reset value.
 * assumes a word reader on ref_clk that answers each held request
 * with a one-cycle ack; mem_present is an asynchronous pin.
 */
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module ecl_loader (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mem_present,
    output ecl_pkg::ecl_mem_req_s mem_req,
    input wire ecl_pkg::ecl_mem_rsp_s mem_rsp,
    output logic cfg_ready,
    output logic no_mem,
    output ecl_pkg::ecl_port_cfg_s [ecl_pkg::PORT_CNT-1:0] port_cfg
);
    ecl_pkg::ecl_state_e state_q;
    logic present_s;
    logic [1:0] settle_q;
    logic [ecl_pkg::IDX_W-1:0] idx_q;
    logic ignore_q;
    logic word_take;
    logic last_word;
    logic [1:0] grp;
    logic [1:0] prt;
    logic [15:0] w;
    logic acc_done;
    logic acc_wr;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_raw;
    logic reload;
    logic [ecl_pkg::WORD_W-1:0] raw_rdata;
    logic [ecl_pkg::IDX_W-1:0] raw_idx;
    logic settle_end;
    logic load_go;
    logic acc_first;
    logic hit_any;
    logic [31:0] rd_word;

    // the presence pin is asynchronous: two flops before any decision
    ecl_sync u_present_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(mem_present),
        .dout(present_s)
    );

    // word index: group in [3:2], port in [1:0]
    assign grp = idx_q[3:2];
    assign prt = idx_q[1:0];
    assign w = mem_rsp.data;
    assign word_take = (state_q == ecl_pkg::ST_WAIT) && mem_req.req
        && mem_rsp.ack;
    assign last_word = (idx_q == 4'(ecl_pkg::WORD_CNT - 1));

    // presence is judged once, when the settle wait has run out
    assign settle_end = (state_q == ecl_pkg::ST_SETTLE)
        && (settle_q == ecl_pkg::SETTLE_CYC);
    assign load_go = present_s && !ignore_q;

    // byte address in the memory: group base plus two per port
    function automatic logic [7:0] word_addr(
        input logic [ecl_pkg::IDX_W-1:0] idx
    );
        logic [7:0] base;
        base = ecl_pkg::SLOT_WORD_BASE;
        unique case (idx[3:2])
            ecl_pkg::GRP_SLOT: base = ecl_pkg::SLOT_WORD_BASE;
            ecl_pkg::GRP_PB: base = ecl_pkg::PB_WORD_BASE;
            ecl_pkg::GRP_PM: base = ecl_pkg::PM_WORD_BASE;
            default: base = ecl_pkg::SLOT_WORD_BASE;
        endcase
        return base + {5'h00, idx[1:0], 1'b0};
    endfunction

    // apb decode
    assign acc_done = psel && penable && pready;
    assign acc_wr = acc_done && pwrite;
    assign hit_ctrl = (paddr == ecl_pkg::ADDR_CTRL);
    assign hit_stat = (paddr == ecl_pkg::ADDR_STAT);
    assign raw_idx = paddr[5:2];
    assign hit_raw = (paddr[11:6] == ecl_pkg::ADDR_RAW[11:6])
        && (paddr[1:0] == 2'h0)
        && (raw_idx < 4'(ecl_pkg::WORD_CNT));
    assign reload = acc_wr && hit_ctrl
        && pwdata[ecl_pkg::CTRL_RELOAD_BIT];

    // load sequencer: settle, then one request per word; a missing
    // or ignored memory goes straight to done
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ecl_pkg::ST_SETTLE;
        end else begin
            unique case (state_q)
                ecl_pkg::ST_IDLE: begin
                    state_q <= ecl_pkg::ST_SETTLE;
                end
                ecl_pkg::ST_SETTLE: begin
                    if (settle_end) begin
                        if (load_go) begin
                            state_q <= ecl_pkg::ST_REQ;
                        end else begin
                            state_q <= ecl_pkg::ST_DONE;
                        end
                    end
                end
                ecl_pkg::ST_REQ: begin
                    state_q <= ecl_pkg::ST_WAIT;
                end
                ecl_pkg::ST_WAIT: begin
                    if (word_take) begin
                        if (last_word) begin
                            state_q <= ecl_pkg::ST_DONE;
                        end else begin
                            state_q <= ecl_pkg::ST_REQ;
                        end
                    end
                end
                ecl_pkg::ST_DONE: begin
                    // a reload while a load runs is ignored
                    if (reload) begin
                        state_q <= ecl_pkg::ST_IDLE;
                    end
                end
                default: state_q <= ecl_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || state_q != ecl_pkg::ST_SETTLE) begin
            settle_q <= 2'h0;
        end else if (settle_q != ecl_pkg::SETTLE_CYC) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // word in flight; it stays on the last word once the load is done
    always_ff @(posedge ref_clk) begin
        if (rst || state_q == ecl_pkg::ST_SETTLE) begin
            idx_q <= '0;
        end else if (word_take && !last_word) begin
            idx_q <= idx_q + 4'h1;
        end
    end

    // memory request, held until the ack
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_req <= '0;
        end else if (state_q == ecl_pkg::ST_REQ) begin
            mem_req.req <= 1'b1;
            mem_req.addr <= word_addr(idx_q);
        end else if (word_take) begin
            mem_req.req <= 1'b0;
        end
    end

    // host config access stays closed until every word is in or the load is skipped; it
    // drops in the cycle a reload is taken, before the fields clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_ready <= 1'b0;
        end else begin
            cfg_ready <= (state_q == ecl_pkg::ST_DONE) && !reload;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            no_mem <= 1'b0;
        end else if (settle_end) begin
            no_mem <= !load_go;
        end
    end

    // field update; a new load starts from the defaults again
    always_ff @(posedge ref_clk) begin
        if (rst || state_q == ecl_pkg::ST_SETTLE) begin
            port_cfg <= {ecl_pkg::PORT_CNT{ecl_pkg::CFG_RST}};
        end else if (word_take) begin
            unique case (grp)
                ecl_pkg::GRP_SLOT: begin
                    port_cfg[prt].slot_impl <=
                        w[ecl_pkg::SLOT_BIT];
                    port_cfg[prt].slot_clk_cfg <=
                        w[ecl_pkg::CLK_BIT];
                    port_cfg[prt].dsi_req <=
                        w[ecl_pkg::DSI_BIT];
                    port_cfg[prt].low_priority_vc_group <=
                        w[ecl_pkg::LOW_PRIO_BIT];
                    port_cfg[prt].port_num <=
                        w[ecl_pkg::PNUM_LSB +: 3];
                    port_cfg[prt].tc_vc0_map <=
                        w[ecl_pkg::TCMAP_LSB +: 7];
                end
                ecl_pkg::GRP_PB: begin
                    port_cfg[prt].base_power <=
                        w[ecl_pkg::BPWR_LSB +: 8];
                    port_cfg[prt].data_scale <=
                        w[ecl_pkg::SCALE_LSB +: 2];
                    port_cfg[prt].pm_state <=
                        w[ecl_pkg::PMST_LSB +: 2];
                    port_cfg[prt].sys_alloc <=
                        w[ecl_pkg::SYSAL_BIT];
                end
                ecl_pkg::GRP_PM: begin
                    // d3-to-l1 [1:0], l1 delay [3:2], l0s [5:4]
                    port_cfg[prt].pm_ctrl <=
                        w[ecl_pkg::PMCTL_LSB +: 6];
                    port_cfg[prt].rx_pol_dis <=
                        w[ecl_pkg::RXPOL_BIT];
                    port_cfg[prt].vga_en <=
                        w[ecl_pkg::VGA_BIT];
                    port_cfg[prt].phy_ctrl_status_five <=
                        w[ecl_pkg::PHY_LSB +: 8];
                end
                default: begin
                end
            endcase
        end
    end

    // raw copy of every loaded word for software readback
    ecl_word_ram u_raw (
        .ref_clk(ref_clk),
        .we(word_take),
        .waddr(idx_q),
        .wdata(w),
        .raddr(raw_idx),
        .rdata_q(raw_rdata)
    );

    // ignore lets software skip a fitted memory on the next load
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ignore_q <= ecl_pkg::CTRL_IGNORE_RST;
        end else if (acc_wr && hit_ctrl) begin
            ignore_q <= pwdata[ecl_pkg::CTRL_IGNORE_BIT];
        end
    end

    // first access-phase cycle; the answer follows one cycle later
    assign acc_first = psel && penable && !pready;
    assign hit_any = hit_ctrl || hit_stat || hit_raw;

    // read word assembled while the access waits
    always_comb begin
        rd_word = 32'h0;
        if (hit_ctrl) begin
            rd_word[ecl_pkg::CTRL_IGNORE_BIT] = ignore_q;
        end else if (hit_stat) begin
            rd_word[ecl_pkg::STAT_BUSY_BIT] = (state_q != ecl_pkg::ST_DONE);
            rd_word[ecl_pkg::STAT_READY_BIT] = cfg_ready;
            rd_word[ecl_pkg::STAT_NOMEM_BIT] = no_mem;
            rd_word[ecl_pkg::STAT_IDX_LSB +: ecl_pkg::IDX_W] = idx_q;
        end else if (hit_raw) begin
            rd_word[ecl_pkg::WORD_W-1:0] = raw_rdata;
        end
    end

    // one wait state so the raw word memory read has settled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= acc_first;
        end
    end

    // unmapped places answer with an error and have no effect
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= acc_first && !hit_any;
        end
    end

    // read data stand only in the cycle pready is high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (acc_first && !pwrite) begin
            prdata <= rd_word;
        end else begin
            prdata <= 32'h0;
        end
    end
endmodule

// File: bench/ecl_loader_properties.sv
/*
 * port-level checks of the preload word loader.
 * assumes binding into ecl_loader with one clock and sync reset.
 */
`timescale 1ns/100ps
module ecl_loader_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ecl_pkg::ecl_mem_req_s mem_req,
    input wire ecl_pkg::ecl_mem_rsp_s mem_rsp,
    input wire logic cfg_ready,
    input wire logic no_mem,
    input wire ecl_pkg::ecl_port_cfg_s [ecl_pkg::PORT_CNT-1:0] port_cfg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic take;
    assign take = mem_req.req && mem_rsp.ack;

    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    read_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    req_hold_a: assert property (mem_req.req && !mem_rsp.ack |=>
        mem_req.req && $stable(mem_req.addr))
        else $error("memory request dropped early");
    req_release_a: assert property (take |=> !mem_req.req)
        else $error("memory request held after ack");
    load_gate_a: assert property (mem_req.req |-> !cfg_ready)
        else $error("ready while loading");
    slot_map_a: assert property (
        take && mem_req.addr[7:4] == 4'h6 |=>
        {port_cfg[$past(mem_req.addr[2:1])].tc_vc0_map,
         port_cfg[$past(mem_req.addr[2:1])].port_num,
         port_cfg[$past(mem_req.addr[2:1])].low_priority_vc_group,
         port_cfg[$past(mem_req.addr[2:1])].dsi_req,
         port_cfg[$past(mem_req.addr[2:1])].slot_clk_cfg,
         port_cfg[$past(mem_req.addr[2:1])].slot_impl} ==
        {$past(mem_rsp.data[15:9]), $past(mem_rsp.data[6:0])})
        else $error("slot word mapped wrongly");
    budget_map_a: assert property (
        take && mem_req.addr[7:4] == 4'h7 |=>
        {port_cfg[$past(mem_req.addr[2:1])].sys_alloc,
         port_cfg[$past(mem_req.addr[2:1])].pm_state,
         port_cfg[$past(mem_req.addr[2:1])].data_scale,
         port_cfg[$past(mem_req.addr[2:1])].base_power} ==
        {$past(mem_rsp.data[15]), $past(mem_rsp.data[11:0])})
        else $error("budget word mapped wrongly");
    pm_map_a: assert property (
        take && mem_req.addr[7:4] == 4'h8 |=>
        {port_cfg[$past(mem_req.addr[2:1])].phy_ctrl_status_five,
         port_cfg[$past(mem_req.addr[2:1])].vga_en,
         port_cfg[$past(mem_req.addr[2:1])].rx_pol_dis,
         port_cfg[$past(mem_req.addr[2:1])].pm_ctrl} ==
        $past(mem_rsp.data))
        else $error("pm word mapped wrongly");
    nomem_default_a: assert property (
        no_mem && cfg_ready |-> port_cfg == '0)
        else $error("fields not default without memory");

    cover property (take && mem_req.addr == 8'h86);
    cover property (pslverr);
    cover property (no_mem && cfg_ready);
endmodule

bind ecl_loader ecl_loader_properties ecl_loader_properties_inst (.*);

// File: bench/ecl_mem_model.sv
/*
 * configuration memory model: answers each held request after dly
 * cycles; data toggle outside the ack cycle.
 */
`timescale 1ns/100ps
module ecl_mem_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] dly,
    input wire logic [15:0] salt,
    input wire ecl_pkg::ecl_mem_req_s mem_req,
    output ecl_pkg::ecl_mem_rsp_s mem_rsp
);
    logic [2:0] cnt_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_rsp <= '0;
            cnt_q <= 3'h0;
        end else if (mem_req.req && !mem_rsp.ack && cnt_q == dly) begin
            mem_rsp.ack <= 1'b1;
            mem_rsp.data <= {mem_req.addr, mem_req.addr ^ 8'h5a} ^ salt;
            cnt_q <= 3'h0;
        end else begin
            mem_rsp.ack <= 1'b0;
            // stale data must never look valid
            mem_rsp.data <= ~mem_rsp.data;
            cnt_q <= (mem_req.req && !mem_rsp.ack) ? cnt_q + 3'h1 : 3'h0;
        end
    end
endmodule

// File: bench/ecl_loader_bench.sv
/*
 * self-checking bench of the preload word loader.
 * assumes the memory model and the bound checker.
 */
`timescale 1ns/100ps
module ecl_loader_bench;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic mem_present = 1, pready, pslverr, cfg_ready, no_mem, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] dly = 3'h0;
    logic [15:0] salt = 16'h0000;
    ecl_pkg::ecl_mem_req_s mem_req;
    ecl_pkg::ecl_mem_rsp_s mem_rsp;
    ecl_pkg::ecl_port_cfg_s [ecl_pkg::PORT_CNT-1:0] port_cfg;
    int miscompares = 0, checked = 0;

    ecl_loader ecl_loader_inst (.*);
    ecl_mem_model ecl_mem_model_inst (.*);

    initial forever #5 ref_clk = ~ref_clk;

    task check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] wd(input logic [7:0] a);
        return {a, a ^ 8'h5a} ^ salt;
    endfunction

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_load;
        int n;
        n = 0;
        while (cfg_ready !== 1'b0 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        while (cfg_ready !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        check(cfg_ready, 1'b1);
    endtask

    task check_ports(input logic none);
        logic [15:0] s, b, m;
        for (int p = 0; p < 4; p++) begin
            s = none ? 16'h0 : wd(8'h60 + 8'(2 * p));
            b = none ? 16'h0 : wd(8'h70 + 8'(2 * p));
            m = none ? 16'h0 : wd(8'h80 + 8'(2 * p));
            check({port_cfg[p].low_priority_vc_group, port_cfg[p].dsi_req,
                port_cfg[p].slot_clk_cfg, port_cfg[p].slot_impl},
                s[3:0]);
            check({port_cfg[p].port_num, port_cfg[p].tc_vc0_map},
                {s[6:4], s[15:9]});
            check({port_cfg[p].sys_alloc, port_cfg[p].pm_state,
                port_cfg[p].data_scale, port_cfg[p].base_power},
                {b[15], b[11:0]});
            check({port_cfg[p].phy_ctrl_status_five, port_cfg[p].vga_en,
                port_cfg[p].rx_pol_dis, port_cfg[p].pm_ctrl},
                m);
        end
    endtask

    task reload(input logic ign, input logic none);
        apb(1'b1, ecl_pkg::ADDR_CTRL, {30'h0, ign, 1'b1});
        apb(1'b0, ecl_pkg::ADDR_STAT, 32'h0);
        check(rd[1:0], 2'h1);
        wait_load;
        check(no_mem, none);
        check_ports(none);
    endtask

    task t_regs;
        logic [15:0] e;
        apb(1'b0, ecl_pkg::ADDR_STAT, 32'h0);
        check(rd[2:0], 3'h2);
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, ecl_pkg::ADDR_RAW + 12'(4 * i), 32'h0);
            e = wd(8'h60 + 8'(16 * (i / 4) + 2 * (i % 4)));
            check(rd, {16'h0, e});
        end
        // unmapped place answers with an error and zero data
        apb(1'b0, 12'h100, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        apb(1'b1, ecl_pkg::ADDR_STAT, 32'hffffffff);
        apb(1'b0, ecl_pkg::ADDR_STAT, 32'h0);
        check({err, rd[2:0]}, 4'h2);
    endtask

    task t_nomem;
        reload(1'b1, 1'b1);
        apb(1'b0, ecl_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, ecl_pkg::ADDR_CTRL, 32'h0);
        mem_present <= 1'b0;
        reload(1'b0, 1'b1);
        mem_present <= 1'b1;
        reload(1'b0, 1'b0);
    endtask

    task report_and_stop;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        wait_load;
        check(no_mem, 1'b0);
        check_ports(1'b0);
        t_regs;
        salt <= 16'hc3a5;
        dly <= 3'h4;
        reload(1'b0, 1'b0);
        t_nomem;
        report_and_stop;
    end

    initial begin
        #500us;
        miscompares++;
        report_and_stop;
    end
endmodule
